/* include/qsm_pkg.sv */
// Opcodes, status layout, phase counts and states of the serial memory command port.
//------------------------------------------------------------------------------
// Contract
// - Link idles in clock mode 0 or 3; the device accepts either idle level.
// - Inputs are sampled on the rising clock edge; outputs change after the falling edge.
// - A frame is an 8-bit opcode, then optional 24-bit address, latency cycles, data.
// - Opcode, address, latency and data bits travel most significant bit first.
// - Write latch flag is cleared at reset; writes are refused until enabled.
// - Array write needs an enable frame first; latch clears when select rises after it.
// - Dual mode uses lanes 0 and 1; quad mode adds protect and pause pins.
// - Array access is ignored while an internal write cycle is busy.
// - Reads stream sequential bytes, wrap to zero, and end when select rises.
// - Fast reads drive the first bit on the falling edge after the last latency cycle.
// - Opcode 06h sets and 04h clears the write latch; both are opcode only.
// - Write latch clears after disable, status write or array write completes.
// - Writes 02h, A2h, 32h take an address, no latency, a bounded byte count.
// - Read 03h has no latency; 0Bh has 8 latency cycles; both stream unlimited bytes.
// - Reads 3Bh and 6Bh return data on two or four lanes after 8 latency cycles.
// - Opcode 05h returns a status byte; 01h accepts one; no address phase.
// - Opcode B9h enters sleep and ABh leaves it; both are opcode-only frames.
// - Opcode 9Fh returns up to three identification bytes.
// - Pause pin low while selected freezes the transfer and floats the outputs.
// - Status bit 7 set with protect pin low blocks status writes.
// - Status bits 4 to 2 guard regions, bit 1 is the latch flag, bits 6, 5 and 0 are zero.
// - A status write executes only if select rises right after the eighth data bit.
//------------------------------------------------------------------------------
package qsm_pkg;

  //----------------------------------------------------------------------------
  // Opcodes
  //----------------------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] OP_SLEEP_ENTER_CMD = 8'hB9;
  localparam logic [7:0] OP_SLEEP_EXIT_CMD = 8'hAB;
  localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_ONE_LANE_WRITE_CMD = 8'h02;
  localparam logic [7:0] OP_TWO_LANE_WRITE_CMD = 8'hA2;
  localparam logic [7:0] OP_FOUR_LANE_WRITE_CMD = 8'h32;
  localparam logic [7:0] OP_PLAIN_READ_CMD = 8'h03;
  localparam logic [7:0] OP_LATENCY_READ_CMD = 8'h0B;
  localparam logic [7:0] OP_TWO_LANE_LATENCY_READ_CMD = 8'h3B;
  localparam logic [7:0] OP_FOUR_LANE_LATENCY_READ_CMD = 8'h6B;
  localparam logic [7:0] OP_IDENTITY_READ_CMD = 8'h9F;

  //----------------------------------------------------------------------------
  // Status register layout and reset values
  //----------------------------------------------------------------------------
  localparam int STATUS_W = 8;
  localparam int ST_GUARD_PIN_ENABLE_BIT = 7;
  localparam logic [7:0] STATUS_WR_MASK = 8'h9C;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  //----------------------------------------------------------------------------
  // Phase counts, lane widths and pin synchroniser layout
  //----------------------------------------------------------------------------
  localparam logic [4:0] OPCODE_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] LATENCY_LAST = 5'h07;
  localparam logic [4:0] STATUS_BITS = 5'h08;
  localparam logic [4:0] CNT_SATURATE = 5'h1F;
  localparam logic [2:0] LANES_ONE = 3'h1;
  localparam logic [2:0] LANES_TWO = 3'h2;
  localparam logic [2:0] LANES_FOUR = 3'h4;
  localparam int SYNC_W = 6;
  localparam int SYN_SCK = 0;
  localparam int SYN_CS = 1;
  localparam int SYN_IO = 2;
  localparam logic [5:0] SYNC_RESET = 6'h3E;

  //----------------------------------------------------------------------------
  // Frame phases
  //----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LATENCY = 3'b010,
    ST_DATA_IN = 3'b011,
    ST_DATA_OUT = 3'b100,
    ST_IGNORE = 3'b101
  } qsm_state_type;

endpackage

/* src/qsm_cmd_port.sv */
// Command front end of a serial memory: pin sampling, frame decode, status and array access.
`timescale 1ns/1ps
module qsm_cmd_port #(
  parameter int ADDR_W = 20,
  parameter int MAX_WR_BYTES = 2048,
  parameter logic [7:0] ID_BYTE0 = 8'h5A, // Arbitrary value.
  parameter logic [7:0] ID_BYTE1 = 8'h3C, // Arbitrary value.
  parameter logic [7:0] ID_BYTE2 = 8'h11  // Arbitrary value.
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Serial link pins, lanes 0 to 3.
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe_n,
  // Memory array side.
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_mem_busy,
  // Device state.
  output logic [qsm_pkg::STATUS_W-1:0] o_status,
  output logic o_sleep
);
  import qsm_pkg::*;

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [3:0] d,
                                          input logic [2:0] l);
    logic [7:0] r;
    r = {b[3:0], d};
    case (l)
      LANES_ONE: r = {b[6:0], d[0]};
      LANES_TWO: r = {b[5:0], d[1:0]};
      default: r = {b[3:0], d};
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] l);
    logic [3:0] r;
    r = b[7:4];
    case (l)
      LANES_ONE: r = {2'h0, b[7], 1'b0};
      LANES_TWO: r = {2'h0, b[7:6]};
      default: r = b[7:4];
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] l);
    logic [3:0] r;
    r = 4'hF;
    case (l)
      LANES_ONE: r = 4'h2;
      LANES_TWO: r = 4'h3;
      default: r = 4'hF;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] last_pos(input logic [2:0] l);
    logic [2:0] r;
    r = 3'h1;
    case (l)
      LANES_ONE: r = 3'h7;
      LANES_TWO: r = 3'h3;
      default: r = 3'h1;
    endcase
    return r;
  endfunction

  function automatic logic is_array_read(input logic [7:0] op);
    return op == OP_PLAIN_READ_CMD || op == OP_LATENCY_READ_CMD ||
           op == OP_TWO_LANE_LATENCY_READ_CMD || op == OP_FOUR_LANE_LATENCY_READ_CMD;
  endfunction

  function automatic logic is_array_write(input logic [7:0] op);
    return op == OP_ONE_LANE_WRITE_CMD || op == OP_TWO_LANE_WRITE_CMD ||
           op == OP_FOUR_LANE_WRITE_CMD;
  endfunction

  // Upper 1/32, 1/16, 1/8, 1/4, 1/2 or all of the array, by the three guard bits.
  function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [2:0] g);
    logic [4:0] top;
    logic r;
    top = a[ADDR_W-1 -: 5];
    r = 1'b0;
    case (g)
      3'h1: r = &top;
      3'h2: r = &top[4:1];
      3'h3: r = &top[4:2];
      3'h4: r = &top[4:3];
      3'h5: r = top[4];
      3'h6, 3'h7: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r, sync2_r, sync3_r, lvl_r, lvl_d_r, lvl_nxt;
  qsm_state_type state_r, dec_state;
  logic [2:0] lanes_r, dec_lanes, pos_r;
  logic [4:0] cnt_r;
  logic [23:0] sh_r;
  logic [7:0] op_r, op_byte, in_byte, out_src, osh_r, rd_byte_r, nv_r, status;
  logic [ADDR_W-1:0] addr_r;
  logic [11:0] wr_cnt_r;
  logic [1:0] id_idx_r;
  logic [3:0] pin, io_r;
  logic wel_r, sleep_r, drv_r, mem_rd_r, rd_cap_r, mem_wr_r, wr_step_r;
  logic [7:0] wdata_r;
  logic cs_act, cs_rise, sck_rise, sck_fall, quad_phase, hold_act, wp_low, run, rise, fall;
  logic opc_done, addr_done, lat_done, in_byte_done, out_start, fetch_now;
  logic stat_commit, wr_end, wr_ok;

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  // A level only changes once the second and third stages agree, so a single
  // metastable sample on the first stage can never produce a false edge.
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      lvl_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : lvl_r[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
      sync3_r <= SYNC_RESET;
      lvl_r <= SYNC_RESET;
      lvl_d_r <= SYNC_RESET;
    end else begin
      sync1_r <= {i_io, i_cs_n, i_sck};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r <= lvl_nxt;
      lvl_d_r <= lvl_r;
    end
  end

  //----------------------------------------------------------------------------
  // Link events
  //----------------------------------------------------------------------------
  // Either clock idle level works: only edges seen while selected count.
  assign sck_rise = lvl_r[SYN_SCK] & ~lvl_d_r[SYN_SCK];
  assign sck_fall = ~lvl_r[SYN_SCK] & lvl_d_r[SYN_SCK];
  assign cs_act = ~lvl_r[SYN_CS];
  assign cs_rise = lvl_r[SYN_CS] & ~lvl_d_r[SYN_CS];
  assign pin = lvl_r[SYN_IO +: 4];
  assign quad_phase = (state_r == ST_DATA_IN || state_r == ST_DATA_OUT) &&
                      lanes_r == LANES_FOUR;
  assign hold_act = cs_act & ~quad_phase & ~pin[3];
  assign wp_low = ~quad_phase & ~pin[2];
  assign run = cs_act & ~hold_act;
  assign rise = run & sck_rise;
  assign fall = run & sck_fall;
  assign op_byte = {sh_r[6:0], pin[0]};
  assign in_byte = shift_in(sh_r[7:0], pin, lanes_r);
  assign out_src = (pos_r == 3'h0) ? rd_byte_r : osh_r;
  assign status = {nv_r[7:2], wel_r, 1'b0};

  assign opc_done = rise && state_r == ST_OPCODE && cnt_r == OPCODE_LAST;
  assign addr_done = rise && state_r == ST_ADDR && cnt_r == ADDR_LAST;
  assign lat_done = rise && state_r == ST_LATENCY && cnt_r == LATENCY_LAST;
  assign in_byte_done = rise && state_r == ST_DATA_IN && pos_r == last_pos(lanes_r);
  assign out_start = fall && state_r == ST_DATA_OUT && pos_r == 3'h0;
  assign fetch_now = (addr_done && is_array_read(op_r)) || lat_done ||
                     (out_start && is_array_read(op_r));
  assign stat_commit = cs_rise && state_r == ST_DATA_IN && op_r == OP_STATUS_WRITE_CMD &&
                       cnt_r == STATUS_BITS && wel_r &&
                       !(nv_r[ST_GUARD_PIN_ENABLE_BIT] && wp_low);
  assign wr_end = cs_rise && state_r == ST_DATA_IN && is_array_write(op_r);
  assign wr_ok = wr_cnt_r < MAX_WR_BYTES[11:0] && !guarded(addr_r, nv_r[4:2]);

  //----------------------------------------------------------------------------
  // Opcode decode
  //----------------------------------------------------------------------------
  always_comb begin
    dec_state = ST_IGNORE;
    dec_lanes = LANES_ONE;
    if (!sleep_r) begin
      unique case (op_byte)
        OP_STATUS_READ_CMD, OP_IDENTITY_READ_CMD: dec_state = ST_DATA_OUT;
        OP_STATUS_WRITE_CMD: dec_state = ST_DATA_IN;
        OP_PLAIN_READ_CMD, OP_LATENCY_READ_CMD: begin
          dec_state = i_mem_busy ? ST_IGNORE : ST_ADDR;
        end
        OP_TWO_LANE_LATENCY_READ_CMD: begin
          dec_state = i_mem_busy ? ST_IGNORE : ST_ADDR;
          dec_lanes = LANES_TWO;
        end
        OP_FOUR_LANE_LATENCY_READ_CMD: begin
          dec_state = i_mem_busy ? ST_IGNORE : ST_ADDR;
          dec_lanes = LANES_FOUR;
        end
        OP_ONE_LANE_WRITE_CMD: begin
          dec_state = (i_mem_busy || !wel_r) ? ST_IGNORE : ST_ADDR;
        end
        OP_TWO_LANE_WRITE_CMD: begin
          dec_state = (i_mem_busy || !wel_r) ? ST_IGNORE : ST_ADDR;
          dec_lanes = LANES_TWO;
        end
        OP_FOUR_LANE_WRITE_CMD: begin
          dec_state = (i_mem_busy || !wel_r) ? ST_IGNORE : ST_ADDR;
          dec_lanes = LANES_FOUR;
        end
        default: dec_state = ST_IGNORE;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Frame sequencer
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_OPCODE;
      cnt_r <= 5'h00;
      pos_r <= 3'h0;
      lanes_r <= LANES_ONE;
      sh_r <= 24'h000000;
      op_r <= 8'h00;
    end else if (!cs_act) begin
      state_r <= ST_OPCODE;
      cnt_r <= 5'h00;
      pos_r <= 3'h0;
      lanes_r <= LANES_ONE;
    end else if (rise) begin
      unique case (state_r)
        ST_OPCODE: begin
          sh_r <= {sh_r[22:0], pin[0]};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == OPCODE_LAST) begin
            op_r <= op_byte;
            state_r <= dec_state;
            lanes_r <= dec_lanes;
            cnt_r <= 5'h00;
          end
        end
        ST_ADDR: begin
          sh_r <= {sh_r[22:0], pin[0]};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == ADDR_LAST) begin
            cnt_r <= 5'h00;
            if (is_array_write(op_r)) begin
              state_r <= ST_DATA_IN;
            end else if (op_r == OP_PLAIN_READ_CMD) begin
              state_r <= ST_DATA_OUT;
            end else begin
              state_r <= ST_LATENCY;
            end
          end
        end
        ST_LATENCY: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == LATENCY_LAST) begin
            state_r <= ST_DATA_OUT;
          end
        end
        ST_DATA_IN: begin
          sh_r[7:0] <= in_byte;
          pos_r <= in_byte_done ? 3'h0 : pos_r + 3'h1;
          if (cnt_r != CNT_SATURATE) begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        ST_DATA_OUT, ST_IGNORE: begin
          cnt_r <= cnt_r;
        end
        default: state_r <= ST_IGNORE;
      endcase
    end else if (fall && state_r == ST_DATA_OUT) begin
      pos_r <= (pos_r == last_pos(lanes_r)) ? 3'h0 : pos_r + 3'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Write latch, status bits and sleep
  //----------------------------------------------------------------------------
  // The guard bits live in flops here; keeping them across power loss is the
  // job of the storage behind this block.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wel_r <= 1'b0;
    end else if (opc_done && !sleep_r && op_byte == OP_SET_WRITE_LATCH_CMD) begin
      wel_r <= 1'b1;
    end else if (opc_done && !sleep_r && op_byte == OP_CLEAR_WRITE_LATCH_CMD) begin
      wel_r <= 1'b0;
    end else if (stat_commit || wr_end) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nv_r <= STATUS_RESET;
    end else if (stat_commit) begin
      nv_r <= sh_r[7:0] & STATUS_WR_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_r <= 1'b0;
    end else if (opc_done && op_byte == OP_SLEEP_ENTER_CMD) begin
      sleep_r <= 1'b1;
    end else if (opc_done && op_byte == OP_SLEEP_EXIT_CMD) begin
      sleep_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Array access and read data
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_r <= '0;
      mem_rd_r <= 1'b0;
      rd_cap_r <= 1'b0;
      mem_wr_r <= 1'b0;
      wr_step_r <= 1'b0;
      wdata_r <= 8'h00;
      wr_cnt_r <= 12'h000;
    end else begin
      mem_rd_r <= fetch_now;
      rd_cap_r <= mem_rd_r;
      wr_step_r <= in_byte_done && is_array_write(op_r);
      mem_wr_r <= in_byte_done && is_array_write(op_r) && wr_ok;
      if (in_byte_done) begin
        wdata_r <= in_byte;
      end
      if (addr_done) begin
        addr_r <= {sh_r[ADDR_W-2:0], pin[0]};
      end else if ((out_start && is_array_read(op_r)) || wr_step_r) begin
        addr_r <= addr_r + 1'b1;
      end
      if (!cs_act) begin
        wr_cnt_r <= 12'h000;
      end else if (wr_step_r && wr_cnt_r != 12'hFFF) begin
        wr_cnt_r <= wr_cnt_r + 12'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_byte_r <= 8'h00;
      id_idx_r <= 2'h0;
    end else if (rd_cap_r) begin
      rd_byte_r <= i_mem_rdata;
    end else if (opc_done && op_byte == OP_STATUS_READ_CMD) begin
      rd_byte_r <= status;
    end else if (opc_done && op_byte == OP_IDENTITY_READ_CMD) begin
      rd_byte_r <= ID_BYTE0;
      id_idx_r <= 2'h1;
    end else if (out_start && op_r == OP_STATUS_READ_CMD) begin
      rd_byte_r <= status;
    end else if (out_start && op_r == OP_IDENTITY_READ_CMD) begin
      rd_byte_r <= (id_idx_r == 2'h1) ? ID_BYTE1 : (id_idx_r == 2'h2) ? ID_BYTE2 : 8'h00;
      id_idx_r <= (id_idx_r == 2'h3) ? id_idx_r : id_idx_r + 2'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Output lanes
  //----------------------------------------------------------------------------
  // The enable is gated live by select and pause, so a pause floats the lanes
  // at once and releasing it drives the held bit again without a new edge.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      io_r <= 4'h0;
      osh_r <= 8'h00;
      drv_r <= 1'b0;
    end else if (!cs_act) begin
      drv_r <= 1'b0;
    end else if (fall && state_r == ST_DATA_OUT) begin
      io_r <= lane_out(out_src, lanes_r);
      osh_r <= shift_in(out_src, 4'h0, lanes_r);
      drv_r <= 1'b1;
    end
  end

  assign o_io = io_r;
  assign o_io_oe_n = (drv_r && run) ? ~lane_mask(lanes_r) : 4'hF;
  assign o_mem_addr = addr_r;
  assign o_mem_rd = mem_rd_r;
  assign o_mem_wr = mem_wr_r;
  assign o_mem_wdata = wdata_r;
  assign o_status = status;
  assign o_sleep = sleep_r;

endmodule // qsm_cmd_port

/* testbench/qsm_cmd_port_props.sv */
// Checker of the serial memory command port, bound to its top module.
`timescale 1ns/1ps
module qsm_cmd_port_props #(
  parameter int ADDR_W = 20
) (
  // Watched pins of the command port.
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_mem_busy,
  input wire logic [3:0] o_io_oe_n,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [qsm_pkg::STATUS_W-1:0] o_status,
  input wire logic o_sleep
);
  import qsm_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_oe_idle; i_cs_n [*8] |-> o_io_oe_n == 4'hF; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while deselected");
  property p_rd_pulse; o_mem_rd |=> !o_mem_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_wr_pulse; o_mem_wr |=> !o_mem_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_wr_latch; o_mem_wr |-> o_status[1]; endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("write without latch");
  property p_busy; i_mem_busy |-> !o_mem_rd && !o_mem_wr; endproperty
  a_busy: assert property (p_busy) else $error("array access while busy");
  property p_sleep; o_sleep |-> o_io_oe_n == 4'hF; endproperty
  a_sleep: assert property (p_sleep) else $error("lanes driven while asleep");
  property p_rsvd; o_status[6:5] == 2'h0 && !o_status[0]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_rst; $rose(i_resetn) |-> o_status == STATUS_RESET; endproperty
  a_rst: assert property (p_rst) else $error("status not clear after reset");
  property p_step; o_mem_wr |-> ##2 (o_mem_addr == $past(o_mem_addr, 2) + 1'b1); endproperty
  a_step: assert property (p_step) else $error("write address did not step");
  property p_lanes; o_io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0}; endproperty
  a_lanes: assert property (p_lanes) else $error("illegal lane group");
  c_wr: cover property (o_mem_wr);
  c_rd: cover property (o_mem_rd ##1 !o_mem_rd);
  c_sleep: cover property ($rose(o_sleep));
endmodule // qsm_cmd_port_props

bind qsm_cmd_port qsm_cmd_port_props #(.ADDR_W(ADDR_W)) u_qsm_cmd_port_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_mem_busy(i_mem_busy),
  .o_io_oe_n(o_io_oe_n), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_status(o_status), .o_sleep(o_sleep));

/* testbench/qsm_host_model.sv */
// Host model: serial bus master that runs frames in clock mode 0 or 3.
`timescale 1ns/1ps
module qsm_host_model (
  input wire logic [3:0] i_pin,
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io,
  output logic [3:0] o_oe
);
  logic cpol = 1'b0;
  logic wp = 1'b1;
  logic hd = 1'b1;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  // The protect and pause pins stay driven between frames, as a host port pin would.
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'hF;
    o_oe = 4'hC;
  end
  task automatic clk1(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
    o_sck = 1'b0;
    o_io = v;
    o_oe = oe;
    #62.5 s = i_pin;
    o_sck = 1'b1;
    #62.5;
  endtask
  task automatic byte_x(input logic [7:0] b, input int ln, input bit rd, output logic [7:0] r);
    logic [3:0] s;
    logic [3:0] v;
    r = 8'h00;
    repeat (8 / ln) begin
      v = (ln == 4) ? b[7:4] : (ln == 2) ? {1'b1, wp, b[7:6]} : {hd, wp, 1'b1, b[7]};
      clk1(v, (ln == 4) ? {4{!rd}} : (ln == 2) ? {2'b11, {2{!rd}}} : 4'hD, s);
      r = (ln == 4) ? {r[3:0], s} : (ln == 2) ? {r[5:0], s[1:0]} : {r[6:0], s[1]};
      b = b << ln;
    end
  endtask
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int na, input int lat,
                      input int ln, input int nw, input int nr);
    logic [7:0] r;
    logic [3:0] s;
    o_sck = cpol;
    #62.5 o_cs_n = 1'b0;
    #62.5 byte_x(op, 1, 1'b0, r);
    repeat (na) begin
      byte_x(a[23:16], 1, 1'b0, r);
      a = a << 8;
    end
    repeat (lat) clk1({1'b1, wp, 2'b11}, 4'hD, s);
    repeat (nw) byte_x(txq.pop_front(), ln, 1'b0, r);
    repeat (nr) begin
      byte_x(8'h00, ln, 1'b1, r);
      rxq.push_back(r);
    end
    o_sck = cpol;
    #62.5 o_cs_n = 1'b1;
    o_io = {1'b1, wp, 2'b11};
    o_oe = 4'hC;
    #600;
  endtask
endmodule // qsm_host_model

/* testbench/tb_qsm_cmd_port.sv */
// Self-checking testbench of the serial memory command port.
`timescale 1ns/1ps
module tb_qsm_cmd_port;
  import qsm_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn, i_mem_busy, sck, cs_n, o_mem_rd, o_mem_wr, o_sleep;
  logic [7:0] i_mem_rdata, o_mem_wdata, o_status, d;
  logic [3:0] h_io, h_oe, pin, o_io, o_io_oe_n;
  logic [19:0] o_mem_addr;
  logic [23:0] a;
  logic [27:0] exp_wr[$];
  logic [7:0] exp_rx[$];
  logic [7:0] wop[3] = '{OP_ONE_LANE_WRITE_CMD, OP_TWO_LANE_WRITE_CMD, OP_FOUR_LANE_WRITE_CMD};
  logic [7:0] rop[4] = '{OP_PLAIN_READ_CMD, OP_LATENCY_READ_CMD, OP_TWO_LANE_LATENCY_READ_CMD,
                         OP_FOUR_LANE_LATENCY_READ_CMD};
  int err_total, cmp_count, cyc, m, i;
  // Identity values are arbitrary.
  qsm_cmd_port #(.ID_BYTE0(8'hC1), .ID_BYTE1(8'h7E), .ID_BYTE2(8'h29)) u_qsm_cmd_port (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sck(sck), .i_cs_n(cs_n), .i_io(pin), .o_io(o_io),
    .o_io_oe_n(o_io_oe_n), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_mem_busy(i_mem_busy),
    .o_status(o_status), .o_sleep(o_sleep));
  qsm_host_model u_qsm_host_model (.i_pin(pin), .o_sck(sck), .o_cs_n(cs_n), .o_io(h_io),
    .o_oe(h_oe));
  // Lanes carry pull-ups, so a released lane reads high.
  assign pin = (~o_io_oe_n & o_io) | (o_io_oe_n & ((h_oe & h_io) | ~h_oe));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] fn(input logic [19:0] x);
    return x[7:0] ^ x[19:12] ^ 8'h5A;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic go(input logic [7:0] op, input int na, input int lat, input int ln,
                    input int nw, input int nr);
    u_qsm_host_model.xfer(op, a, na, lat, ln, nw, nr);
  endtask
  task automatic st(input logic [7:0] ex);
    exp_rx.push_back(ex);
    go(OP_STATUS_READ_CMD, 0, 0, 1, 0, 1);
  endtask
  task automatic put(input logic [7:0] x);
    u_qsm_host_model.txq.push_back(x);
  endtask
  // Watcher: compares each array write and each returned byte with the oldest note.
  always @(posedge i_clk) begin
    #1;
    cyc++;
    if (o_mem_wr) chk("mem write", {o_mem_addr, o_mem_wdata},
                      exp_wr.size() ? exp_wr.pop_front() : 'x);
    if (u_qsm_host_model.rxq.size() != 0)
      chk("read byte", u_qsm_host_model.rxq.pop_front(),
          exp_rx.size() ? exp_rx.pop_front() : 'x);
    if (o_mem_rd) i_mem_rdata = fn(o_mem_addr);
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    i_resetn = 1'b0;
    i_mem_busy = 1'b0;
    i_mem_rdata = 8'h00;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    a = 24'h0;
    void'($urandom(97021));
    repeat (6) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    repeat (8) @(posedge i_clk);
    chk("status", o_status, STATUS_RESET);
    chk("sleep", o_sleep, 1'b0);
    put(8'h11);
    put(8'h22);
    go(OP_ONE_LANE_WRITE_CMD, 3, 0, 1, 2, 0);
    for (m = 0; m < 3; m++) begin
      u_qsm_host_model.cpol = m[0];
      go(OP_SET_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
      st(8'h02);
      a = {4'h0, 20'($urandom)};
      for (i = 0; i < 2; i++) begin
        d = 8'($urandom);
        put(d);
        exp_wr.push_back({a[19:0] + 20'(i), d});
      end
      go(wop[m], 3, 0, 1 << m, 2, 0);
      st(8'h00);
    end
    for (m = 0; m < 4; m++) begin
      a = (m == 0) ? 24'h0FFFFE : {4'h0, 20'($urandom)};
      for (i = 0; i < 3; i++) exp_rx.push_back(fn(a[19:0] + 20'(i)));
      go(rop[m], 3, (m == 0) ? 0 : 8, (m == 3) ? 4 : (m == 2) ? 2 : 1, 0, 3);
    end
    exp_rx = '{8'hC1, 8'h7E, 8'h29, 8'h00, 8'hFF};
    go(OP_IDENTITY_READ_CMD, 0, 0, 1, 0, 4);
    go(8'hFF, 0, 0, 1, 0, 1);
    @(posedge i_clk) #1 i_mem_busy = 1'b1;
    exp_rx.push_back(8'hFF);
    go(OP_PLAIN_READ_CMD, 3, 0, 1, 0, 1);
    @(posedge i_clk) #1 i_mem_busy = 1'b0;
    go(OP_SLEEP_ENTER_CMD, 0, 0, 1, 0, 0);
    chk("sleep", o_sleep, 1'b1);
    st(8'hFF);
    go(OP_SLEEP_EXIT_CMD, 0, 0, 1, 0, 0);
    chk("sleep", o_sleep, 1'b0);
    go(OP_SET_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
    go(OP_CLEAR_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
    st(8'h00);
    go(OP_SET_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
    put(8'hFF);
    go(OP_STATUS_WRITE_CMD, 0, 0, 1, 1, 0);
    st(STATUS_WR_MASK);
    go(OP_SET_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
    u_qsm_host_model.wp = 1'b0;
    put(8'h00);
    go(OP_STATUS_WRITE_CMD, 0, 0, 1, 1, 0);
    st(8'h9E);
    u_qsm_host_model.wp = 1'b1;
    put(8'h00);
    put(8'h00);
    go(OP_STATUS_WRITE_CMD, 0, 0, 1, 2, 0);
    st(8'h9E);
    put(8'h00);
    go(OP_STATUS_WRITE_CMD, 0, 0, 1, 1, 0);
    st(8'h00);
    u_qsm_host_model.hd = 1'b0;
    go(OP_SET_WRITE_LATCH_CMD, 0, 0, 1, 0, 0);
    u_qsm_host_model.hd = 1'b1;
    st(8'h00);
    repeat (20) @(posedge i_clk);
    report_and_stop();
  end
endmodule // tb_qsm_cmd_port
